// *** rtl/bmd_pkg.sv ***
// Shared types, opcode patterns and the opcode decode function for the byte move decoder
package bmd_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Operand kinds for source and destination
  typedef enum logic [2:0] {
    OPD_ACC = 3'b000,
    OPD_IMM = 3'b001,
    OPD_DIR = 3'b010,
    OPD_REG = 3'b011,
    OPD_IND = 3'b100,
    OPD_BIT = 3'b101,
    OPD_CRY = 3'b110
  } bmd_opd_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_OPC = 3'b000,
    ST_OPR = 3'b001,
    ST_PREP = 3'b010,
    ST_PTRW = 3'b011,
    ST_LOAD = 3'b100,
    ST_EXEC = 3'b101
  } bmd_state_t;

  // Decoded instruction: legality, length, machine cycles, operand kinds
  typedef struct packed {
    logic legal;
    logic [1:0] bytes;
    logic [1:0] cycles;
    bmd_opd_t src;
    bmd_opd_t dst;
  } bmd_dec_t;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Opcode values and field layout
  localparam logic [7:0] OP_DIR_DIR = 8'h85;
  localparam logic [7:0] OP_DIR_IMM = 8'h75;
  localparam logic [7:0] OP_DIR_ACC = 8'hf5;
  localparam logic [7:0] OP_ACC_IMM = 8'h74;
  localparam logic [7:0] OP_CRY_BIT = 8'ha2;
  localparam logic [7:0] OP_BIT_CRY = 8'h92;
  localparam int REG_LSB = 0;
  localparam int PTR_BIT = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] BIT_AREA_HI = 4'h2;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // Builds a decode entry
  function automatic bmd_dec_t mk(input logic [1:0] b, input logic [1:0] c,
                                  input bmd_opd_t s, input bmd_opd_t d);
    mk = '{legal: 1'b1, bytes: b, cycles: c, src: s, dst: d};
  endfunction

  // Opcode byte to decoded form
  function automatic bmd_dec_t decode(input logic [7:0] op);
    decode = '{legal: 1'b0, bytes: LEN_1, cycles: LEN_1, src: OPD_ACC, dst: OPD_ACC};
    casez (op)
      8'b1110011?: decode = mk(LEN_1, LEN_1, OPD_IND, OPD_ACC);
      OP_ACC_IMM:  decode = mk(LEN_2, LEN_1, OPD_IMM, OPD_ACC);
      8'b11111???: decode = mk(LEN_1, LEN_1, OPD_ACC, OPD_REG);
      8'b10101???: decode = mk(LEN_2, LEN_2, OPD_DIR, OPD_REG);
      8'b01111???: decode = mk(LEN_2, LEN_1, OPD_IMM, OPD_REG);
      OP_DIR_ACC:  decode = mk(LEN_2, LEN_1, OPD_ACC, OPD_DIR);
      8'b10001???: decode = mk(LEN_2, LEN_2, OPD_REG, OPD_DIR);
      OP_DIR_DIR:  decode = mk(LEN_3, LEN_2, OPD_DIR, OPD_DIR);
      8'b1000011?: decode = mk(LEN_2, LEN_2, OPD_IND, OPD_DIR);
      OP_DIR_IMM:  decode = mk(LEN_3, LEN_2, OPD_IMM, OPD_DIR);
      8'b1111011?: decode = mk(LEN_1, LEN_1, OPD_ACC, OPD_IND);
      8'b1010011?: decode = mk(LEN_2, LEN_2, OPD_DIR, OPD_IND);
      8'b0111011?: decode = mk(LEN_2, LEN_1, OPD_IMM, OPD_IND);
      OP_CRY_BIT:  decode = mk(LEN_2, LEN_1, OPD_BIT, OPD_CRY);
      OP_BIT_CRY:  decode = mk(LEN_2, LEN_2, OPD_CRY, OPD_BIT);
      default:     decode = decode;
    endcase
  endfunction

  // Address of a bank register in the active bank
  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] idx);
    bank_addr = {3'b000, bank, idx};
  endfunction

endpackage

// *** rtl/bmd_ram.sv ***
// Internal data memory, 256 bytes, one write port and a registered read port
module bmd_ram
  import bmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [7:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_raddr,
  output logic [7:0] o_rdata
);

  logic [7:0] mem [0:255];
  logic [7:0] rdata_r;

  // Write port
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data comes out one cycle after the address
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= RST_BYTE;
    end else begin
      rdata_r <= mem[i_raddr];
    end
  end

  assign o_rdata = rdata_r;

endmodule

// *** rtl/bmd_core.sv ***
// Byte and bit move decoder with its small execution datapath
//////////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Opcode 1110011i loads accumulator from RAM at selected pointer, one cycle.
// - Opcode 11111rrr copies accumulator into the selected bank register, one cycle.
// - Direct-to-bank-register form copies the directly addressed byte into that register.
// - Opcode 11110101 plus direct byte stores the accumulator there, one cycle.
// - Three-byte direct move copies source location to destination, source unchanged.
// - Opcode 1000011i plus direct byte copies indirect byte to direct, 2 bytes 2 cycles.
// - Opcode 01110101, direct then immediate byte, writes immediate; 3 bytes 2 cycles.
// - Opcode 1111011i writes accumulator into RAM at selected pointer, one cycle.
// - Opcode 1010011i plus direct byte copies direct byte to indirect RAM, 2 bytes.
// - Bit moves only pair the carry with any directly addressable bit.
// - A bit move changes only its destination bit, nothing else.
module bmd_core
  import bmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_code_valid,
  input wire logic [7:0] i_code_byte,
  input wire logic [1:0] i_bank,
  output logic o_code_ready,
  output logic o_done,
  output bmd_dec_t o_info,
  output logic [7:0] o_acc,
  output logic o_carry
);

  //////////////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // State and datapath registers
  bmd_state_t state_r;
  bmd_state_t state_nxt;
  bmd_dec_t dec_r;
  logic [7:0] op_r;
  logic [7:0] opr1_r;
  logic [7:0] opr2_r;
  logic [1:0] left_r;
  logic [7:0] ptr_r;
  logic [7:0] acc_r;
  logic carry_r;
  logic done_r;
  bmd_dec_t info_r;
  logic [7:0] ram_rdata;

  // Fetch handshake and operand bookkeeping
  wire take = o_code_ready && i_code_valid;
  wire bmd_dec_t dec_new = decode(i_code_byte);
  wire last_opr = (left_r == LEN_1);
  wire need_ptr = (dec_r.src == OPD_IND) || (dec_r.dst == OPD_IND);
  assign o_code_ready = (state_r == ST_OPC) || (state_r == ST_OPR);

  wire [7:0] reg_addr = bank_addr(i_bank, op_r[REG_LSB +: 3]);
  wire [7:0] ptr_addr = bank_addr(i_bank, {2'b00, op_r[PTR_BIT]});

  // Direct byte address of a bit, and the bit position inside it
  wire [7:0] bit_byte = opr1_r[7] ? {opr1_r[7:3], 3'b000} : {BIT_AREA_HI, opr1_r[6:3]};
  wire [2:0] bit_pos = opr1_r[2:0];

  // destination is the second operand when both are direct
  wire [7:0] dst_dir = (dec_r.src == OPD_DIR) ? opr2_r : opr1_r;
  wire [7:0] imm_val = (dec_r.dst == OPD_DIR) ? opr2_r : opr1_r;

  wire [7:0] src_addr = (dec_r.src == OPD_DIR) ? opr1_r :
                        (dec_r.src == OPD_REG) ? reg_addr :
                        (dec_r.src == OPD_IND) ? ptr_r : bit_byte;
  wire [7:0] dst_addr = (dec_r.dst == OPD_DIR) ? dst_dir :
                        (dec_r.dst == OPD_REG) ? reg_addr :
                        (dec_r.dst == OPD_IND) ? ptr_r : bit_byte;
  wire [7:0] load_addr = (dec_r.dst == OPD_BIT) ? dst_addr : src_addr;
  wire [7:0] rd_addr = (state_r == ST_PREP) ? ptr_addr : load_addr;

  wire [7:0] src_val = (dec_r.src == OPD_ACC) ? acc_r :
                       (dec_r.src == OPD_IMM) ? imm_val : ram_rdata;
  wire src_bit = ram_rdata[bit_pos];

  // only the addressed bit takes the carry
  wire [7:0] bit_wdata;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign bit_wdata[g] = (bit_pos == 3'(g)) ? carry_r : ram_rdata[g];
    end
  endgenerate

  wire exec = (state_r == ST_EXEC) && dec_r.legal;
  wire dst_mem = (dec_r.dst == OPD_DIR) || (dec_r.dst == OPD_REG) ||
                 (dec_r.dst == OPD_IND) || (dec_r.dst == OPD_BIT);
  wire we = exec && dst_mem;
  wire [7:0] wdata = (dec_r.dst == OPD_BIT) ? bit_wdata : src_val;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OPC: begin
        if (take) begin
          state_nxt = (dec_new.bytes == LEN_1) ? ST_PREP : ST_OPR;
        end
      end
      ST_OPR: begin
        if (take && last_opr) begin
          state_nxt = ST_PREP;
        end
      end
      ST_PREP: begin
        state_nxt = !dec_r.legal ? ST_EXEC : (need_ptr ? ST_PTRW : ST_LOAD);
      end
      ST_PTRW: state_nxt = ST_LOAD;
      ST_LOAD: state_nxt = ST_EXEC;
      ST_EXEC: state_nxt = ST_OPC;
      default: state_nxt = ST_OPC;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OPC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Opcode and operand capture
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= RST_BYTE;
      dec_r <= '0;
      opr1_r <= RST_BYTE;
      opr2_r <= RST_BYTE;
      left_r <= 2'h0;
    end else if (take && state_r == ST_OPC) begin
      op_r <= i_code_byte;
      dec_r <= dec_new;
      left_r <= dec_new.bytes - LEN_1;
    end else if (take) begin
      opr1_r <= (left_r == dec_r.bytes - LEN_1) ? i_code_byte : opr1_r;
      opr2_r <= (left_r == dec_r.bytes - LEN_1) ? opr2_r : i_code_byte;
      left_r <= left_r - LEN_1;
    end
  end

  // Pointer register value fetched for indirect forms
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= RST_BYTE;
    end else if (state_r == ST_PTRW) begin
      ptr_r <= ram_rdata;
    end
  end

  // carry only from a bit source
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= RST_BYTE;
      carry_r <= 1'b0;
    end else if (exec) begin
      acc_r <= (dec_r.dst == OPD_ACC) ? src_val : acc_r;
      carry_r <= (dec_r.dst == OPD_CRY) ? src_bit : carry_r;
    end
  end

  // Completion pulse and report of the finished instruction
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      info_r <= '0;
    end else begin
      done_r <= (state_r == ST_EXEC);
      info_r <= (state_r == ST_EXEC) ? dec_r : info_r;
    end
  end

  assign o_done = done_r;
  assign o_info = info_r;
  assign o_acc = acc_r;
  assign o_carry = carry_r;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Internal data memory
  bmd_ram u_ram (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_we(we),
    .i_waddr(dst_addr),
    .i_wdata(wdata),
    .i_raddr(rd_addr),
    .o_rdata(ram_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_ind_acc_load: assert property (
    (state_r == ST_LOAD && op_r[7:1] == 7'b1110011) |-> rd_addr == ptr_r
    ##1 exec ##1 acc_r == $past(ram_rdata))
    else $error("indirect load did not reach accumulator");

  a_reg_acc_store: assert property (
    (exec && op_r[7:3] == 5'b11111) |-> we && dst_addr == {3'b000, i_bank, op_r[2:0]}
    && wdata == acc_r)
    else $error("accumulator not stored to bank register");

  a_dir_reg_copy: assert property (
    (state_r == ST_LOAD && op_r[7:3] == 5'b10101) |-> rd_addr == opr1_r
    ##1 (we && dst_addr == reg_addr && wdata == ram_rdata))
    else $error("direct byte not copied to bank register");

  a_acc_dir_store: assert property (
    (exec && op_r == 8'hf5) |-> we && dst_addr == opr1_r && wdata == acc_r)
    else $error("accumulator not stored to direct address");

  a_dir_dir_order: assert property (
    (state_r == ST_LOAD && op_r == 8'h85) |-> rd_addr == opr1_r
    ##1 (we && dst_addr == opr2_r && wdata == ram_rdata))
    else $error("direct to direct move used wrong addresses");

  a_ind_dir_len: assert property (
    (state_r == ST_OPC && take && i_code_byte[7:1] == 7'b1000011)
    |=> dec_r.bytes == 2'h2 && dec_r.cycles == 2'h2 && o_code_ready
    ##1 (!$past(take) || !o_code_ready))
    else $error("indirect to direct length wrong");

  a_imm_dir_write: assert property (
    (exec && op_r == 8'h75) |-> we && dst_addr == opr1_r && wdata == opr2_r
    && dec_r.bytes == 2'h3 && dec_r.cycles == 2'h2)
    else $error("immediate not written to direct address");

  a_acc_ind_store: assert property (
    (state_r == ST_PTRW && op_r[7:1] == 7'b1111011) |=> ##1 (we && dst_addr == ptr_r
    && wdata == acc_r && ptr_r == $past(ram_rdata, 2)))
    else $error("accumulator not stored through pointer");

  a_dir_ind_copy: assert property (
    (exec && op_r[7:1] == 7'b1010011) |-> we && dst_addr == ptr_r
    && wdata == ram_rdata && dec_r.bytes == 2'h2)
    else $error("direct byte not copied through pointer");

  a_bit_carry_pair: assert property (
    (exec && (dec_r.src == OPD_BIT || dec_r.dst == OPD_BIT)) |->
    (dec_r.src == OPD_CRY || dec_r.dst == OPD_CRY) ##1 carry_r == $past(dec_r.dst == OPD_CRY
    ? src_bit : carry_r))
    else $error("bit move not paired with carry");

  a_bit_side_free: assert property (
    (exec && dec_r.dst == OPD_BIT) |-> (((wdata ^ ram_rdata) & ~(8'h01 << bit_pos)) == 8'h00)
    ##1 $stable(acc_r) && $stable(carry_r))
    else $error("bit move touched more than its bit");

  a_bank_field: assert property (
    (we && dec_r.dst == OPD_REG) |-> dst_addr[7:5] == 3'b000 && dst_addr[4:3] == i_bank)
    else $error("bank register outside active bank");

  c_dir_dir: cover property (exec && op_r == 8'h85);
  c_bit_to_carry: cover property (exec && op_r == 8'ha2 ##1 carry_r);
  c_carry_to_bit: cover property (exec && op_r == 8'h92);
  c_illegal: cover property (state_r == ST_EXEC && !dec_r.legal);

endmodule

// *** sim/tb.sv ***
// Self-checking bench for the byte and bit move decoder, with a behavioural model
module tb
  import bmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Stimulus, observed outputs and model state
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_code_valid = 1'b0;
  logic [7:0] i_code_byte = 8'h00;
  logic [1:0] i_bank = 2'h0;
  logic o_code_ready;
  logic o_done;
  logic o_carry;
  logic [7:0] o_acc;
  bmd_dec_t o_info;
  int n_errors = 0;
  int check_count = 0;
  int mem [256];
  int acc = 0;
  int cy = 0;
  int bk = 0;
  logic [31:0] seed = 32'd39989;

  // Core clock, 25 ns period
  always #12.5 i_clk = ~i_clk;

  bmd_core uut (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_code_valid(i_code_valid),
    .i_code_byte(i_code_byte),
    .i_bank(i_bank),
    .o_code_ready(o_code_ready),
    .o_done(o_done),
    .o_info(o_info),
    .o_acc(o_acc),
    .o_carry(o_carry)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // Helpers: random source, compare, verdict
  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Address of bank register r in the active bank
  function automatic int ra(input int r);
    return (bk * 8) + r;
  endfunction

  // Byte holding a bit address: low area packed from 20h, upper area on 8-byte bounds
  function automatic int bbyte(input int b);
    return (b < 128) ? (32 + ((b >> 3) & 15)) : (b & 248);
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////
  // Reference model: updates state, returns length, machine cycles, legality, pointer use
  task automatic model(input int op, input int b1, input int b2, output int nb,
                       output int nc, output int lg, output int ptr);
    int p;
    int q;
    int bb;
    int bi;
    nb = 1;
    nc = 1;
    lg = 1;
    ptr = 0;
    p = mem[ra(op & 1)];
    q = mem[ra(op & 7)];
    bb = bbyte(b1);
    bi = b1 & 7;
    casez (8'(op))
      8'b1110011?: begin acc = mem[p]; ptr = 1; end
      8'h74: begin acc = b1; nb = 2; end
      8'b11111???: mem[ra(op & 7)] = acc;
      8'b10101???: begin mem[ra(op & 7)] = mem[b1]; nb = 2; nc = 2; end
      8'b01111???: begin mem[ra(op & 7)] = b1; nb = 2; end
      8'hf5: begin mem[b1] = acc; nb = 2; end
      8'b10001???: begin mem[b1] = q; nb = 2; nc = 2; end
      8'h85: begin mem[b2] = mem[b1]; nb = 3; nc = 2; end
      8'b1000011?: begin mem[b1] = mem[p]; nb = 2; nc = 2; ptr = 1; end
      8'h75: begin mem[b1] = b2; nb = 3; nc = 2; end
      8'b1111011?: begin mem[p] = acc; ptr = 1; end
      8'b1010011?: begin mem[p] = mem[b1]; nb = 2; nc = 2; ptr = 1; end
      8'b0111011?: begin mem[p] = b1; nb = 2; ptr = 1; end
      8'ha2: begin cy = (mem[bb] >> bi) & 1; nb = 2; end
      8'h92: begin mem[bb] = (mem[bb] & ~(1 << bi)) | (cy << bi); nb = 2; nc = 2; end
      default: lg = 0;
    endcase
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  // Fetch port driver: offer one byte and hold it until the edge that takes it
  task automatic put(input int b);
    int k;
    i_code_valid <= 1'b1;
    i_code_byte <= 8'(b);
    k = 0;
    // Ready is read between edges, so the byte stands through the edge that takes it
    #1;
    while (o_code_ready !== 1'b1 && k < 20) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    @(posedge i_clk);
  endtask

  // One instruction: send its bytes, wait for completion, compare with the model
  task automatic run(input int op, input int b1, input int b2, input int bank);
    int nb;
    int nc;
    int lg;
    int ptr;
    int k;
    @(posedge i_clk);
    bk = bank;
    i_bank <= 2'(bank);
    model(op, b1, b2, nb, nc, lg, ptr);
    put(op);
    if (nb > 1) begin
      put(b1);
    end
    if (nb > 2) begin
      put(b2);
    end
    i_code_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (o_done !== 1'b1 && k < 20);
    // completion latency, illegal codes skip the load
    chk(16'(k), 16'(!lg ? 2 : ptr ? 4 : 3));
    chk(16'({o_info.legal, o_info.bytes, o_info.cycles}), 16'({lg[0], nb[1:0], nc[1:0]}));
    chk(16'(o_acc), 16'(acc));
    chk(16'(o_carry), 16'(cy));
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int a;
    int b;
    repeat (6) @(posedge i_clk);
    // Outputs cleared while reset is held
    chk(16'({o_done, o_carry, o_acc}), 16'h0000);
    chk(16'(o_info), 16'h0000);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    for (a = 0; a < 256; a++) begin
      run(8'h75, a, int'(xrand() & 255), int'(xrand() & 3));
    end
    $display("test fill done");
    // Every opcode value once, legal and not
    for (a = 0; a < 256; a++) begin
      run(a, int'(xrand() & 255), int'(xrand() & 255), int'(xrand() & 3));
    end
    $display("test all opcodes done");
    repeat (1500) begin
      run(int'(xrand() & 255), int'(xrand() & 255), int'(xrand() & 255), int'(xrand() & 3));
    end
    $display("test random mix done");
    // Reset in mid-run: outputs clear, memory keeps its contents
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(16'({o_done, o_carry, o_acc}), 16'h0000);
    chk(16'(o_info), 16'h0000);
    acc = 0;
    cy = 0;
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    $display("test mid reset done");
    // read back every location through pointer zero
    for (a = 0; a < 256; a++) begin
      b = int'(xrand() & 3);
      run(8'h78, a, 0, b);
      run(8'he6, 0, 0, b);
    end
    $display("test readback done");
    tally_and_finish();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge i_clk);
    n_errors++;
    $display("watchdog expired at t=%0t", $time);
    tally_and_finish();
  end

endmodule
